// file: hdl/ssp_pkg.sv
package ssp_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_MODE  = 8'h00;
    localparam logic [7:0] ADDR_RATE  = 8'h04;
    localparam logic [7:0] ADDR_CTRL  = 8'h08;
    localparam logic [7:0] ADDR_TXBUF = 8'h0c;
    localparam logic [7:0] ADDR_RXBUF = 8'h10;
    localparam logic [7:0] ADDR_STAT  = 8'h14;

    // ----------------------------------------
    // Serial mode field codes
    // ----------------------------------------
    localparam logic [2:0] MD_OFF  = 3'h0;
    localparam logic [2:0] MD_SYNC = 3'h1;
    localparam logic [2:0] MD_I2C  = 3'h2;
    localparam logic [2:0] MD_A7   = 3'h4;
    localparam logic [2:0] MD_A9   = 3'h6;

    // ----------------------------------------
    // Field layouts, low bit first from the bottom
    // ----------------------------------------
    typedef struct packed {
        logic       cont_rx;
        logic       cts_en;
        logic       rts_en;
        logic       clk_pol;
        logic       par_en;
        logic       even_par;
        logic       two_stop;
        logic       ext_clk;
        logic [2:0] serial_mode_field;
    } ssp_mode_t;

    typedef struct packed {
        logic [1:0] src;
        logic [7:0] div;
    } ssp_rate_t;

    localparam int        MODE_W     = 11;
    localparam int        RATE_W     = 10;
    localparam int        CTRL_TE    = 0;
    localparam int        CTRL_RE    = 1;
    localparam int        RXB_ERR    = 12;
    localparam logic [MODE_W-1:0] MODE_RST = 11'h000;
    localparam logic [RATE_W-1:0] RATE_RST = 10'h000;

    // Count sources of the bit-rate divider
    localparam logic [1:0] SRC_DIV1 = 2'h0;
    localparam logic [1:0] SRC_DIV8 = 2'h1;
    localparam logic [1:0] SRC_DIV32 = 2'h2;
    localparam logic [1:0] SRC_PIN  = 2'h3;
    localparam logic [4:0] DIV8_LAST  = 5'h07;
    localparam logic [4:0] DIV32_LAST = 5'h1f;

    // ----------------------------------------
    // Timing counts
    // ----------------------------------------
    localparam logic [3:0] OSR_LAST   = 4'hf;
    localparam logic [3:0] OSR_MID    = 4'h7;
    localparam logic [2:0] SY_LAST    = 3'h7;
    localparam logic [2:0] SY_OVR_BIT = 3'h6;
    localparam logic [3:0] CHAR_MIN   = 4'h7;
endpackage

// file: hdl/ssp_top.sv
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
module ssp_top
    import ssp_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        SHIFT_CLOCK_PIN_I,
    output logic             SHIFT_CLOCK_PIN_O,
    output logic             SHIFT_CLOCK_PIN_OE,
    input  wire logic        SERIAL_IN_PIN,
    output logic             SERIAL_OUT_PIN,
    input  wire logic        CLEAR_TO_SEND_IN_N,
    output logic             READY_TO_RECEIVE_OUT_N,
    output logic             RX_DONE_PULSE
);
    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    ssp_mode_t   mode_r;
    ssp_rate_t   rate_r;
    logic        te_r, re_r;
    logic [8:0]  tbuf_r, rbuf_r;
    logic        tbuf_full_r, rx_cpl_r, ovr_r, fer_r, per_r;
    logic        ph_wr_r;
    logic [7:0]  ph_adr_r;
    logic [31:0] rdata_r;
    logic        acc, rd_rx, wr_mode, wr_rate, wr_ctrl, wr_tbuf;
    logic        tx_reset, rx_clr, err_sum;
    logic        sy_act_r, at_act_r, ar_act_r;

    assign acc      = HSEL && HREADY && HTRANS[1];
    assign rd_rx    = acc && !HWRITE && HADDR[7:0] == ADDR_RXBUF;
    assign wr_mode  = ph_wr_r && ph_adr_r == ADDR_MODE;
    assign wr_rate  = ph_wr_r && ph_adr_r == ADDR_RATE;
    assign wr_ctrl  = ph_wr_r && ph_adr_r == ADDR_CTRL;
    assign wr_tbuf  = ph_wr_r && ph_adr_r == ADDR_TXBUF;
    assign tx_reset = wr_mode && HWDATA[2:0] == MD_OFF;
    assign rx_clr   = tx_reset || (wr_ctrl && !HWDATA[CTRL_RE]);
    assign err_sum  = ovr_r || fer_r || per_r;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = rdata_r;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ph_wr_r  <= 1'b0;
            ph_adr_r <= 8'h00;
        end else begin
            ph_wr_r  <= acc && HWRITE;
            ph_adr_r <= HADDR[7:0];
        end
    end

    // Read data is captured in the address phase so the data phase sees a flop
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_r <= 32'h0000_0000;
        end else if (acc && !HWRITE) begin
            case (HADDR[7:0])
                ADDR_MODE:  rdata_r <= {21'h0, mode_r};
                ADDR_RATE:  rdata_r <= {22'h0, rate_r};
                ADDR_CTRL:  rdata_r <= {30'h0, re_r, te_r};
                ADDR_TXBUF: rdata_r <= {23'h0, tbuf_r};
                ADDR_RXBUF: rdata_r <= {16'h0, err_sum, per_r, fer_r, ovr_r, 3'h0, rbuf_r};
                ADDR_STAT:  rdata_r <= {25'h0, err_sum, per_r, fer_r, ovr_r, rx_cpl_r,
                                        !(sy_act_r || at_act_r), !tbuf_full_r};
                default:    rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_r <= MODE_RST;
            rate_r <= RATE_RST;
            te_r   <= 1'b0;
            re_r   <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode_r <= HWDATA[MODE_W-1:0];
            end
            if (wr_rate) begin
                rate_r <= HWDATA[RATE_W-1:0];
            end
            if (wr_ctrl) begin
                te_r <= HWDATA[CTRL_TE];
                re_r <= HWDATA[CTRL_RE];
            end
        end
    end

    // ----------------------------------------
    // Core clock division and bit-rate divider
    // ----------------------------------------
    logic [4:0] pre_r;
    logic [7:0] brg_r;
    logic       pin_prev_r, src_en, tick;
    logic       is_sync, is_async, ext, cts_ok;
    logic [3:0] cw, clen;

    assign is_sync  = mode_r.serial_mode_field == MD_SYNC;
    assign is_async = mode_r.serial_mode_field[2] && mode_r.serial_mode_field != 3'h7;
    assign ext      = mode_r.ext_clk;
    assign cts_ok   = !mode_r.cts_en || !CLEAR_TO_SEND_IN_N;
    assign cw       = CHAR_MIN + {2'h0, mode_r.serial_mode_field[1:0]};
    assign clen     = 4'h2 + cw + {3'h0, mode_r.par_en} + {3'h0, mode_r.two_stop};

    always_comb begin
        case (rate_r.src)
            SRC_DIV1:  src_en = 1'b1;
            SRC_DIV8:  src_en = pre_r[2:0] == DIV8_LAST[2:0];
            SRC_DIV32: src_en = pre_r == DIV32_LAST;
            default:   src_en = SHIFT_CLOCK_PIN_I && !pin_prev_r;
        endcase
    end
    assign tick = src_en && brg_r == 8'h00;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pre_r      <= 5'h00;
            pin_prev_r <= 1'b1;
            brg_r      <= 8'h00;
        end else begin
            pre_r      <= pre_r + 5'h01;
            pin_prev_r <= SHIFT_CLOCK_PIN_I;
            if (wr_rate) begin
                brg_r <= HWDATA[7:0];
            end else if (tick) begin
                brg_r <= rate_r.div;
            end else if (src_en) begin
                brg_r <= brg_r - 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Synchronous shifter
    // ----------------------------------------
    logic       clk_lvl_r, armed, lead, samp, e_cur, e_prv;
    logic [2:0] sy_cnt_r;
    logic [7:0] tsh_r, rsh_r;
    logic       sy_ovr_r, sy_done, sy_take;

    // Dummy data in the buffer is what lets a receive-only link clock
    assign armed = is_sync && te_r && tbuf_full_r && cts_ok && !sy_act_r;
    assign e_cur = SHIFT_CLOCK_PIN_I ^ mode_r.clk_pol;
    assign e_prv = pin_prev_r ^ mode_r.clk_pol;
    assign lead  = ext ? (e_prv && !e_cur) : (tick && clk_lvl_r && (armed || sy_act_r));
    assign samp  = ext ? (!e_prv && e_cur) : (tick && !clk_lvl_r && sy_act_r);
    assign sy_take = lead && armed;
    assign sy_done = samp && sy_act_r && sy_cnt_r == SY_LAST;
    assign SHIFT_CLOCK_PIN_O  = clk_lvl_r ^ mode_r.clk_pol;
    assign SHIFT_CLOCK_PIN_OE = is_sync && !ext;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            clk_lvl_r <= 1'b1;
        end else if (!is_sync || ext) begin
            clk_lvl_r <= 1'b1;
        end else if (tick && (armed || sy_act_r)) begin
            clk_lvl_r <= !clk_lvl_r;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sy_act_r <= 1'b0;
            sy_cnt_r <= 3'h0;
            tsh_r    <= 8'hff;
            rsh_r    <= 8'h00;
            sy_ovr_r <= 1'b0;
        end else if (!is_sync || tx_reset) begin
            sy_act_r <= 1'b0;
        end else begin
            if (sy_take) begin
                sy_act_r <= 1'b1;
                sy_cnt_r <= 3'h0;
                tsh_r    <= tbuf_r[7:0];
                sy_ovr_r <= 1'b0;
            end else if (lead && sy_act_r) begin
                tsh_r <= {1'b1, tsh_r[7:1]};
            end
            if (samp && sy_act_r) begin
                rsh_r    <= {SERIAL_IN_PIN, rsh_r[7:1]};
                sy_cnt_r <= sy_cnt_r + 3'h1;
                if (sy_cnt_r == SY_OVR_BIT && rx_cpl_r) begin
                    sy_ovr_r <= 1'b1;
                end
                if (sy_cnt_r == SY_LAST) begin
                    sy_act_r <= 1'b0;
                end
            end
        end
    end

    // Internal clock leaves the line inactive: the partner is paced by our clock
    assign READY_TO_RECEIVE_OUT_N = !(is_sync && ext && mode_r.rts_en && re_r
                                      && !sy_act_r);

    // ----------------------------------------
    // Asynchronous transmitter
    // ----------------------------------------
    logic [12:0] at_fr_r, frame;
    logic [3:0]  at_cnt_r, at_idx_r;
    logic        at_take;

    function automatic logic [12:0] mk_frame(input logic [8:0] d, input logic [3:0] w,
                                             input logic pe, input logic ev);
        logic [12:0] f;
        logic        p;
        f    = 13'h1fff;
        f[0] = 1'b0;
        p    = !ev;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(w)) begin
                f[i+1] = d[i];
                p      = p ^ d[i];
            end
        end
        if (pe) begin
            f[w+4'h1] = p;
        end
        return f;
    endfunction

    assign frame   = mk_frame(tbuf_r, cw, mode_r.par_en, mode_r.even_par);
    assign at_take = tick && !at_act_r && is_async && te_r && tbuf_full_r && cts_ok;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            at_act_r <= 1'b0;
            at_fr_r  <= 13'h1fff;
            at_cnt_r <= 4'h0;
            at_idx_r <= 4'h0;
        end else if (!is_async || tx_reset) begin
            at_act_r <= 1'b0;
        end else if (at_take) begin
            at_act_r <= 1'b1;
            at_fr_r  <= frame;
            at_cnt_r <= 4'h0;
            at_idx_r <= 4'h0;
        end else if (tick && at_act_r) begin
            at_cnt_r <= at_cnt_r + 4'h1;
            if (at_cnt_r == OSR_LAST) begin
                at_fr_r  <= {1'b1, at_fr_r[12:1]};
                at_idx_r <= at_idx_r + 4'h1;
                if (at_idx_r == clen - 4'h1) begin
                    at_act_r <= 1'b0;
                end
            end
        end
    end

    assign SERIAL_OUT_PIN = is_sync ? (sy_act_r ? tsh_r[0] : 1'b1)
                                    : (at_act_r ? at_fr_r[0] : 1'b1);

    // ----------------------------------------
    // Asynchronous receiver, independent of the transmitter
    // ----------------------------------------
    logic [12:0] ar_f_r;
    logic [3:0]  ar_cnt_r, ar_idx_r;
    logic        ar_fin_r, ar_fer, ar_per, pchk;
    logic [8:0]  ar_data;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ar_act_r <= 1'b0;
            ar_f_r   <= 13'h0000;
            ar_cnt_r <= 4'h0;
            ar_idx_r <= 4'h0;
            ar_fin_r <= 1'b0;
        end else begin
            ar_fin_r <= 1'b0;
            if (!is_async || !re_r || rx_clr) begin
                ar_act_r <= 1'b0;
            end else if (tick && !ar_act_r) begin
                if (!SERIAL_IN_PIN) begin
                    ar_act_r <= 1'b1;
                    ar_cnt_r <= 4'h0;
                    ar_idx_r <= 4'h0;
                end
            end else if (tick) begin
                ar_cnt_r <= ar_cnt_r + 4'h1;
                if (ar_cnt_r == OSR_MID) begin
                    if (ar_idx_r == 4'h0 && SERIAL_IN_PIN) begin
                        ar_act_r <= 1'b0;
                    end else begin
                        ar_f_r[ar_idx_r] <= SERIAL_IN_PIN;
                        ar_idx_r         <= ar_idx_r + 4'h1;
                        if (ar_idx_r == clen - 4'h1) begin
                            ar_act_r <= 1'b0;
                            ar_fin_r <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    always_comb begin
        ar_data = 9'h000;
        pchk    = !mode_r.even_par;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(cw)) begin
                ar_data[i] = ar_f_r[i+1];
                pchk       = pchk ^ ar_f_r[i+1];
            end
        end
        ar_per = mode_r.par_en && (pchk != ar_f_r[cw+4'h1]);
        ar_fer = !ar_f_r[cw+4'h1+{3'h0, mode_r.par_en}]
                 || (mode_r.two_stop && !ar_f_r[cw+4'h2+{3'h0, mode_r.par_en}]);
    end

    // ----------------------------------------
    // Transmit and receive buffers, error flags
    // ----------------------------------------
    logic rx_load, new_ovr;

    assign rx_load = (sy_done && re_r) || ar_fin_r;
    assign new_ovr = is_sync ? (sy_ovr_r || (sy_cnt_r == SY_OVR_BIT && rx_cpl_r))
                             : rx_cpl_r;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tbuf_r      <= 9'h000;
            tbuf_full_r <= 1'b0;
        end else begin
            if (tx_reset) begin
                tbuf_full_r <= 1'b0;
            end else if (wr_tbuf) begin
                tbuf_full_r <= 1'b1;
            end else if (sy_take || at_take) begin
                tbuf_full_r <= 1'b0;
            end else if (rd_rx && is_sync && mode_r.cont_rx && re_r) begin
                tbuf_full_r <= 1'b1;
            end
            if (wr_tbuf) begin
                tbuf_r <= HWDATA[8:0];
            end
        end
    end

    // Setting events take priority over clears landing in the same cycle
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rbuf_r   <= 9'h000;
            rx_cpl_r <= 1'b0;
            ovr_r    <= 1'b0;
            fer_r    <= 1'b0;
            per_r    <= 1'b0;
        end else if (rx_load) begin
            rbuf_r   <= is_sync ? {1'b0, SERIAL_IN_PIN, rsh_r[7:1]} : ar_data;
            rx_cpl_r <= 1'b1;
            ovr_r    <= (ovr_r && !rx_clr) || new_ovr;
            fer_r    <= (fer_r && !rx_clr && !rd_rx) || (!is_sync && ar_fer);
            per_r    <= (per_r && !rx_clr && !rd_rx) || (!is_sync && ar_per);
        end else if (rx_clr) begin
            rx_cpl_r <= 1'b0;
            ovr_r    <= 1'b0;
            fer_r    <= 1'b0;
            per_r    <= 1'b0;
        end else if (rd_rx) begin
            rx_cpl_r <= 1'b0;
            fer_r    <= 1'b0;
            per_r    <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RX_DONE_PULSE <= 1'b0;
        end else begin
            RX_DONE_PULSE <= rx_load && !new_ovr;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic rts_mode;
    assign rts_mode = is_sync && ext && mode_r.rts_en;

    sequence s_rx_start;
        rts_mode && re_r && $rose(sy_act_r);
    endsequence
    sequence s_rx_end;
        rts_mode && re_r && sy_done && !tx_reset && !wr_mode && !wr_ctrl;
    endsequence

    AST_RTS_RISE: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_rx_start |-> READY_TO_RECEIVE_OUT_N) else $error("rts not high at start");
    AST_RTS_FALL: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_rx_end |=> !READY_TO_RECEIVE_OUT_N) else $error("rts not low after rx");
    AST_RTS_INT: assert property (@(posedge CLK) disable iff (!RESET_N)
        is_sync && !ext |-> READY_TO_RECEIVE_OUT_N) else $error("rts active on internal clock");
    AST_SY_FIRST: assert property (@(posedge CLK) disable iff (!RESET_N)
        $rose(sy_act_r) |-> SERIAL_OUT_PIN == $past(tbuf_r[0])) else $error("sync bit0 wrong");
    AST_SY_OVR: assert property (@(posedge CLK) disable iff (!RESET_N)
        rx_load && is_sync && sy_ovr_r |=> ovr_r && !RX_DONE_PULSE) else $error("sync overrun");
    AST_START_LOW: assert property (@(posedge CLK) disable iff (!RESET_N)
        $rose(at_act_r) |-> !SERIAL_OUT_PIN ##1 !SERIAL_OUT_PIN) else $error("start not low");
    AST_STOP_HIGH: assert property (@(posedge CLK) disable iff (!RESET_N)
        at_act_r && at_idx_r >= clen - 4'h1 - {3'h0, mode_r.two_stop} |-> SERIAL_OUT_PIN)
        else $error("stop not high");
    AST_DIV: assert property (@(posedge CLK) disable iff (!RESET_N)
        tick && rate_r == {SRC_DIV1, 8'h02} && !wr_rate |=> !tick ##1 !tick ##1 tick)
        else $error("divider period wrong");
    AST_FER: assert property (@(posedge CLK) disable iff (!RESET_N)
        ar_fin_r && ar_fer |=> fer_r && err_sum) else $error("framing flag missing");
    AST_CLR: assert property (@(posedge CLK) disable iff (!RESET_N)
        rx_clr && !rx_load |=> !ovr_r && !fer_r && !per_r) else $error("errors not cleared");
endmodule

// file: tb/ssp_far_end.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far-end IC, loops data back
// ----------------------------------------
module ssp_far_end (
    input  wire logic CLK,
    input  wire logic tx_line,
    input  wire logic brk,
    output logic      rx_line,
    output logic      cts_n
);
    // Held low so every transfer may start
    assign cts_n = 1'b0;
    // Break drags the line low to provoke a framing fault
    always_ff @(posedge CLK) begin
        rx_line <= brk ? 1'b0 : tx_line;
    end
endmodule

// file: tb/ssp_top_tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// Loopback bench
// ----------------------------------------
module sync_async_serial_port_tb_top;
    import ssp_pkg::*;
    logic        CLK = 0, RESET_N = 0, HSEL = 0, HWRITE = 0, brk = 0;
    logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, rd_v, d;
    logic [1:0]  HTRANS = '0;
    logic        HREADYOUT, so, si, cts_n, done;
    logic        sck = 1'b1, sck_o, sck_oe, rts_n;
    ssp_mode_t   m;
    logic [31:0] exp_q[$];
    int          err_total = 0, total_checks = 0, seed;
    event        rd_ev;
    always #10 CLK = ~CLK;
    ssp_top dut_u (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(),
        .SHIFT_CLOCK_PIN_I(sck), .SHIFT_CLOCK_PIN_O(sck_o), .SHIFT_CLOCK_PIN_OE(sck_oe),
        .SERIAL_IN_PIN(si), .SERIAL_OUT_PIN(so), .CLEAR_TO_SEND_IN_N(cts_n),
        .READY_TO_RECEIVE_OUT_N(rts_n), .RX_DONE_PULSE(done));
    ssp_far_end far_u (.CLK(CLK), .tx_line(so), .brk(brk), .rx_line(si),
        .cts_n(cts_n));
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge CLK);
        HSEL <= 1'b1; HTRANS <= 2'h2; HADDR <= {24'h0, a}; HWRITE <= w;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= wd;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd_v = HRDATA;
        if (!w) ->rd_ev;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // Bounded: longest frame is 13 cells of 16 ticks
    task automatic wait_done;
        int n;
        n = 0;
        while (done !== 1'b1 && n < 600) begin
            @(negedge CLK);
            n++;
        end
        if (n >= 600) chk("rx_done", 1, 0);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(rd_ev) chk("read", exp_q.pop_front(), rd_v);
    initial begin
        #400000;
        err_total++;
        end_sim();
    end
    initial begin
        seed = 32'h8777db38;
        repeat (5) @(posedge CLK);
        RESET_N <= 1'b1;
        bus(1, ADDR_RATE, {22'h0, SRC_DIV1, 8'h00});
        bus(1, ADDR_CTRL, 32'h3);
        // Every char length, with and without parity, random stops
        for (int k = 0; k < 6; k++) begin
            m = '0;
            m.serial_mode_field = MD_A7 + 3'(k % 3);
            m.par_en = (k > 2);
            m.even_par = 1'($random(seed));
            m.two_stop = 1'($random(seed));
            d = $random(seed) & ((32'h1 << (7 + k % 3)) - 1);
            bus(1, ADDR_MODE, 32'(m));
            exp_q.push_back(d);
            bus(1, ADDR_TXBUF, d);
            wait_done();
            bus(0, ADDR_RXBUF, 0);
        end
        // Broken stop bit sets framing and sum flags
        m.par_en = 1'b0;
        bus(1, ADDR_MODE, 32'(m));
        brk <= 1'b1;
        exp_q.push_back(32'h0000a000);
        wait_done();
        brk <= 1'b0;
        bus(0, ADDR_RXBUF, 0);
        // Divide by three so the loopback flop settles before each sample
        bus(1, ADDR_RATE, {22'h0, SRC_DIV1, 8'h02});
        m = '0;
        m.serial_mode_field = MD_SYNC;
        bus(1, ADDR_MODE, 32'(m));
        @(negedge CLK);
        chk("clk_oe", 1, sck_oe);
        chk("clk_idle", 1, sck_o);
        chk("rts_int", 1, rts_n);
        // Third item lands while the second is unread: overrun
        for (int k = 0; k < 3; k++) begin
            d = $random(seed) & 32'hff;
            bus(1, ADDR_TXBUF, d);
            if (k < 2) begin
                wait_done();
            end else begin
                repeat (80) @(posedge CLK);
            end
            if (k != 1) begin
                exp_q.push_back((k == 2) ? (d | 32'h9000) : d);
                bus(0, ADDR_RXBUF, 0);
            end
        end
        bus(1, ADDR_CTRL, 32'h0);
        exp_q.push_back(32'h3);
        bus(0, ADDR_STAT, 0);
        // External clock with request line; the bench paces the pin
        m.ext_clk = 1'b1;
        m.rts_en  = 1'b1;
        bus(1, ADDR_MODE, 32'(m));
        @(negedge CLK);
        chk("rts_off", 1, rts_n);
        chk("clk_oe_ext", 0, sck_oe);
        bus(1, ADDR_CTRL, 32'h2);
        @(negedge CLK);
        chk("rts_ready", 0, rts_n);
        bus(1, ADDR_CTRL, 32'h3);
        d = $random(seed) & 32'hff;
        exp_q.push_back(d);
        bus(1, ADDR_TXBUF, d);
        for (int b = 0; b < 8; b++) begin
            sck <= 1'b0;
            repeat (3) @(posedge CLK);
            if (b == 0) chk("rts_busy", 1, rts_n);
            sck <= 1'b1;
            repeat (3) @(posedge CLK);
        end
        @(negedge CLK);
        chk("rts_done", 0, rts_n);
        bus(0, ADDR_RXBUF, 0);
        end_sim();
    end
endmodule
